// >>> logic/offline_pwm_fault_sequencer.v
`timescale 1ns/10ps
`default_nettype none
`include "pwm_seq_consts.vh"
module offline_pwm_fault_sequencer #(
  parameter [1:0] VARIANT = 2'd0,
  parameter [31:0] SS_CYCLES = (`SS_TIME_US * (`CLK_KHZ / 1000)),
  parameter [31:0] RESTART_CYCLES = (`RESTART_TIME_MS * `CLK_KHZ)
)(
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_bulk_above_start,
  input wire i_vdd_above_on,
  input wire i_vdd_above_hv_on,
  input wire i_vdd_above_off,
  input wire i_pwm_trip,
  input wire i_ocp_trip,
  input wire [7:0] i_limit_set,
  input wire i_feedback_grounded,
  input wire i_comp_above_upper,
  input wire i_comp_below_burst,
  input wire i_comp_above_burst_hys,
  input wire i_clamp_above_threshold,
  output reg o_gate,
  output reg o_hv_source_on,
  output reg o_run_charge,
  output reg [7:0] o_current_limit,
  output reg o_limit_capped,
  output reg o_standby,
  output reg o_burst,
  output reg o_overload_off,
  output reg o_open_loop_fault,
  output reg o_feedback_pullup,
  output reg o_err_amp_en,
  output reg o_int_comp_res
);

  ////////////////////////////////////////////////////////////////////////
  // Derived timing
  // Period in core cycles for a frequency in kHz
  function [15:0] period_of;
    input [31:0] khz;
    reg [31:0] full; // Unclipped quotient
    begin
      full = `CLK_KHZ / khz;
      period_of = full[15:0];
    end
  endfunction

  // Nominal and jitter-extreme periods per variant
  localparam [31:0] FNOM = (VARIANT == 2'd0) ? `FSW_30_KHZ :
    (VARIANT == 2'd1) ? `FSW_60_KHZ : `FSW_115_KHZ;
  localparam [31:0] FJIT = (VARIANT == 2'd0) ? `JIT_30_KHZ :
    (VARIANT == 2'd1) ? `JIT_60_KHZ : `JIT_115_KHZ;
  localparam [15:0] PER_MIN = period_of(FNOM + FJIT);
  localparam [15:0] PER_MAX = period_of(FNOM - FJIT);
  // Step of the triangular period sweep; one half moves 15 steps, 15/16 of the jitter range
  localparam [31:0] PER_STEP_W = (PER_MAX - PER_MIN) / `JIT_STEPS;
  localparam [15:0] PER_STEP = PER_STEP_W[15:0];
  // Last step index of a half triangle
  localparam [31:0] JIT_LAST_W = `JIT_STEPS - 1;
  localparam [4:0] JIT_LAST = JIT_LAST_W[4:0];
  // Switching cycles per triangle step so a full triangle lasts 1/230 s
  localparam [31:0] JIT_DIV_W =
    (FNOM * 1000) / (`JIT_MOD_HZ * 2 * `JIT_STEPS);
  localparam [15:0] JIT_DIV = JIT_DIV_W[15:0];
  // Overload trip count in switching cycles
  localparam [31:0] OVL_CNT_W = `OVL_TIME_MS * FNOM;
  localparam [15:0] OVL_CNT = OVL_CNT_W[15:0];
  // Core cycles per soft-start step
  localparam [31:0] SS_STEP_CYC = SS_CYCLES / `SS_STEPS;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer states
  localparam [4:0] S_OFF = 5'b00001; // Lockout, waiting bulk
  localparam [4:0] S_CHARGE = 5'b00010; // Startup charging
  localparam [4:0] S_SOFT = 5'b00100; // Soft-start ramp
  localparam [4:0] S_RUN = 5'b01000; // Normal operation
  localparam [4:0] S_WAIT = 5'b10000; // Overload restart wait

  reg [4:0] state_q; // Sequencer state
  reg [4:0] state_d;
  reg [15:0] per_q; // Current period length
  reg [15:0] phase_q; // Position in switching period
  reg [15:0] jit_div_q; // Switching cycles since last jitter step
  reg jit_up_q; // Sweep direction
  reg [4:0] jit_pos_q; // Step within half triangle
  reg on_q; // Switch on-time active
  reg [15:0] ovl_q; // Overload up-down counter
  reg lim_hit_q; // Limit seen in this cycle
  reg [31:0] tmr_q; // Restart / soft-start timer
  reg [7:0] ss_lim_q; // Soft-start limit ramp
  reg burst_q; // Burst off state
  reg [7:0] user_lim; // Limit from limit-set input
  reg [7:0] lim_sel; // Effective limit
  wire run_ok; // Switching permitted
  wire cyc_start; // First cycle of a period
  wire cyc_end;
  wire [31:0] duty_end; // Phase at which the duty ceiling ends on-time

  assign cyc_start = (phase_q == 16'h0000);
  assign cyc_end = (phase_q == per_q - 16'h0001);
  assign run_ok = (state_q == S_SOFT) || (state_q == S_RUN);
  assign duty_end = (per_q * `DMAX_PCT) / 100;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always @*
  begin
    state_d = state_q;
    case (state_q)
      S_OFF:
      begin
        if (i_bulk_above_start)
          state_d = S_CHARGE;
      end
      S_CHARGE:
      begin
        if (i_vdd_above_on)
          state_d = S_SOFT;
      end
      S_SOFT:
      begin
        if (!i_vdd_above_off)
          state_d = S_OFF;
        else if (ovl_q >= OVL_CNT)
          state_d = S_WAIT;
        else if (tmr_q >= SS_CYCLES)
          state_d = S_RUN;
      end
      S_RUN:
      begin
        if (!i_vdd_above_off)
          state_d = S_OFF;
        else if (ovl_q >= OVL_CNT)
          state_d = S_WAIT;
      end
      S_WAIT:
      begin
        if (!i_vdd_above_off)
          state_d = S_OFF;
        else if (tmr_q >= RESTART_CYCLES - 32'd1)
          state_d = S_SOFT;
      end
      default:
        state_d = S_OFF;
    endcase
  end

  // State register and shared timer; timer restarts at each state entry
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= S_OFF;
      tmr_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      if (state_d != state_q)
        tmr_q <= 32'h0000_0000;
      else if (tmr_q != 32'hffff_ffff)
        tmr_q <= tmr_q + 32'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator with triangular period jitter
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      phase_q <= 16'h0000;
      per_q <= PER_MIN;
      jit_div_q <= 16'h0000;
      jit_up_q <= 1'b1;
      jit_pos_q <= 5'd0;
    end
    else if (cyc_end)
    begin
      phase_q <= 16'h0000;
      // Step the period, or turn the sweep at the last step, once per JIT_DIV switching cycles
      if (jit_div_q >= JIT_DIV - 16'h0001)
      begin
        jit_div_q <= 16'h0000;
        if (jit_pos_q == JIT_LAST)
        begin
          jit_pos_q <= 5'd0;
          jit_up_q <= ~jit_up_q;
        end
        else
        begin
          jit_pos_q <= jit_pos_q + 5'd1;
          per_q <= jit_up_q ? per_q + PER_STEP : per_q - PER_STEP;
        end
      end
      else
        jit_div_q <= jit_div_q + 16'h0001;
    end
    else
      phase_q <= phase_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////
  // Current limit selection
  always @*
  begin
    // Open pin or large resistor leaves the default limit
    if (i_limit_set >= `LIMSET_OPEN)
      user_lim = `ILIM_FULL;
    else
      user_lim = i_limit_set;
    if (burst_q || i_comp_below_burst)
      lim_sel = `ILIM_BURST;
    else if (state_q == S_SOFT && ss_lim_q < user_lim)
      lim_sel = ss_lim_q;
    else
      lim_sel = user_lim;
  end

  // Soft-start ramp, restarted on every soft-start entry
  always @(posedge i_clk)
  begin
    if (i_sys_rst || state_q != S_SOFT)
      ss_lim_q <= `ILIM_SS_START;
    else if (tmr_q != 32'd0 && (tmr_q % SS_STEP_CYC) == 32'd0 &&
             ss_lim_q < `ILIM_FULL - 8'h0f)
      ss_lim_q <= ss_lim_q + 8'h0f;
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst hysteresis
  always @(posedge i_clk)
  begin
    if (i_sys_rst || !run_ok)
      burst_q <= 1'b0;
    else if (i_comp_below_burst)
      burst_q <= 1'b1;
    else if (i_comp_above_burst_hys)
      burst_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // On-time control and overload counter
  always @(posedge i_clk)
  begin
    if (i_sys_rst || !run_ok)
    begin
      on_q <= 1'b0;
      lim_hit_q <= 1'b0;
      ovl_q <= 16'h0000;
    end
    else
    begin
      if (cyc_start)
        on_q <= !burst_q && !i_comp_below_burst;
      // Burst entry cuts a running on-time rather than waiting for a trip
      else if (burst_q || i_comp_below_burst)
        on_q <= 1'b0;
      else if (i_ocp_trip)
        on_q <= 1'b0;
      else if (i_pwm_trip)
        on_q <= 1'b0;
      else if (phase_q >= duty_end[15:0])
        on_q <= 1'b0; // Duty ceiling
      // Limit flag for this cycle
      if (cyc_end)
        lim_hit_q <= 1'b0;
      else if (i_ocp_trip && on_q)
        lim_hit_q <= 1'b1;
      // Up-down count once per switching cycle, saturating
      if (cyc_end)
      begin
        if (lim_hit_q || (i_ocp_trip && on_q))
        begin
          if (ovl_q < OVL_CNT)
            ovl_q <= ovl_q + 16'h0001;
        end
        else if (ovl_q != 16'h0000)
          ovl_q <= ovl_q - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_gate <= 1'b0;
      o_hv_source_on <= 1'b0;
      o_run_charge <= 1'b0;
      o_current_limit <= `ILIM_SS_START;
      o_limit_capped <= 1'b0;
      o_standby <= 1'b1;
      o_burst <= 1'b0;
      o_overload_off <= 1'b0;
      o_open_loop_fault <= 1'b0;
      o_feedback_pullup <= 1'b1;
      o_err_amp_en <= 1'b1;
      o_int_comp_res <= 1'b0;
    end
    else
    begin
      // Gate only from the on-time flop, low in lockout
      o_gate <= on_q && run_ok;
      // Startup source during charge; in run only below hv threshold
      o_hv_source_on <= (state_q == S_CHARGE) ||
        (run_ok && !i_vdd_above_hv_on && !on_q);
      // Same on-time flop as the gate, so the two never overlap
      o_run_charge <= run_ok && !i_vdd_above_hv_on && !on_q;
      o_current_limit <= lim_sel;
      o_limit_capped <= i_comp_above_upper;
      o_standby <= !run_ok || burst_q;
      o_burst <= burst_q;
      o_overload_off <= (state_q == S_WAIT);
      // Both conditions needed; bad aux design alone is not a fault
      o_open_loop_fault <= run_ok && (lim_hit_q || i_ocp_trip) &&
        i_clamp_above_threshold;
      o_feedback_pullup <= 1'b1;
      o_err_amp_en <= !i_feedback_grounded;
      o_int_comp_res <= i_feedback_grounded;
    end
  end

endmodule
`default_nettype wire

// >>> logic/pwm_seq_consts.vh
`ifndef PWM_SEQ_CONSTS_VH
`define PWM_SEQ_CONSTS_VH
// Core clock rate in kHz (200 MHz)
`define CLK_KHZ 200000
// Nominal switching frequencies per variant, kHz
`define FSW_30_KHZ 30
`define FSW_60_KHZ 60
`define FSW_115_KHZ 115
// Jitter depth per variant, kHz
`define JIT_30_KHZ 3
`define JIT_60_KHZ 4
`define JIT_115_KHZ 8
// Jitter modulation rate, Hz
`define JIT_MOD_HZ 230
// Soft-start time, us
`define SS_TIME_US 8500
// Overload time, ms
`define OVL_TIME_MS 50
// Restart wait, ms
`define RESTART_TIME_MS 1000
// Soft-start steps of the current-limit ramp
`define SS_STEPS 16
// Jitter steps per half triangle
`define JIT_STEPS 16
// Current limit code widths and values
`define ILIM_W 8
`define ILIM_FULL 8'hff
`define ILIM_BURST 8'h3d
`define ILIM_SS_START 8'h10
// Limit-set code at or above which the default applies (open pin)
`define LIMSET_OPEN 8'hff
// Maximum duty as on-time fraction, percent
`define DMAX_PCT 75
`endif

// >>> verif/offline_pwm_fault_sequencer_props.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Port watcher for the start-up, burst and protection sequencing
module pwm_seq_props (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_bulk_above_start,
  input wire logic i_vdd_above_on,
  input wire logic i_vdd_above_hv_on,
  input wire logic i_vdd_above_off,
  input wire logic [7:0] i_limit_set,
  input wire logic i_feedback_grounded,
  input wire logic i_clamp_above_threshold,
  input wire logic o_gate,
  input wire logic o_hv_source_on,
  input wire logic o_run_charge,
  input wire logic [7:0] o_current_limit,
  input wire logic o_burst,
  input wire logic o_open_loop_fault,
  input wire logic o_feedback_pullup,
  input wire logic o_err_amp_en,
  input wire logic o_int_comp_res
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Supply under shutdown long enough for two register stages
  sequence uvlo_s;
    !i_vdd_above_off [*3];
  endsequence
  // Start-up source charging the supply capacitor
  sequence charging_s;
    o_hv_source_on && !i_vdd_above_on;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  gate_uvlo_a: assert property (uvlo_s |-> !o_gate)
    else $error("gate high under lockout");
  startup_src_a: assert property (uvlo_s ##1
    (i_bulk_above_start && !i_vdd_above_off) [*3] |-> o_hv_source_on)
    else $error("start-up source not on");
  src_off_a: assert property (charging_s ##1
    (i_vdd_above_on && i_vdd_above_off) [*3] |-> !o_hv_source_on)
    else $error("start-up source still on");
  run_chg_a: assert property (o_run_charge |-> !o_gate)
    else $error("run charge during on-time");
  aux_src_a: assert property ((i_vdd_above_hv_on && i_vdd_above_off) [*3]
    |-> !o_run_charge)
    else $error("run charge with supply high");
  burst_gate_a: assert property (o_burst && $past(o_burst) |-> !o_gate)
    else $error("gate high in burst off");
  burst_lim_a: assert property (o_burst [*3] |-> o_current_limit <= 8'h3d)
    else $error("burst limit too high");
  limit_set_a: assert property ($stable(i_limit_set) [*3]
    |-> o_current_limit <= i_limit_set)
    else $error("limit above set code");
  open_loop_a: assert property (o_open_loop_fault |->
    $past(i_clamp_above_threshold) || $past(i_clamp_above_threshold, 2))
    else $error("open-loop fault without clamp current");
  fb_gnd_a: assert property (i_feedback_grounded [*3]
    |-> !o_err_amp_en && o_int_comp_res)
    else $error("isolated mode not applied");
  pullup_a: assert property (o_feedback_pullup)
    else $error("feedback pull-up missing");
endmodule
// Attach to every sequencer instance
bind offline_pwm_fault_sequencer pwm_seq_props u_props (.i_clk, .i_sys_rst,
  .i_bulk_above_start, .i_vdd_above_on, .i_vdd_above_hv_on, .i_vdd_above_off,
  .i_limit_set, .i_feedback_grounded, .i_clamp_above_threshold, .o_gate,
  .o_hv_source_on, .o_run_charge, .o_current_limit, .o_burst,
  .o_open_loop_fault, .o_feedback_pullup, .o_err_amp_en, .o_int_comp_res);
`default_nettype wire

// >>> verif/flyback_stage_model.sv
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Power stage seen through the current comparators
module flyback_stage_model (
  input wire logic i_clk,
  input wire logic i_gate,
  input wire logic i_heavy,
  output logic o_pwm_trip,
  output logic o_ocp_trip
);
  logic [7:0] on_cnt_q; // Sensed current ramp, cycles of on-time
  // Ramp restarts each on-time; saturates so a stuck gate keeps tripping
  always @(posedge i_clk)
    on_cnt_q <= i_gate ? on_cnt_q + {7'h00, on_cnt_q != 8'hff} : 8'h00;
  // Light load meets the loop level, heavy load reaches the limit first
  assign o_pwm_trip = !i_heavy && on_cnt_q >= 8'h28;
  assign o_ocp_trip = i_heavy && on_cnt_q >= 8'h14;
endmodule
`default_nettype wire

// >>> verif/offline_pwm_fault_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module offline_pwm_fault_sequencer_tb_top;
  localparam logic [31:0] SS = 32'h640; // Shortened soft-start
  logic i_clk, i_sys_rst, i_bulk_above_start, i_vdd_above_on;
  logic i_vdd_above_hv_on, i_vdd_above_off, i_pwm_trip, i_ocp_trip;
  logic i_feedback_grounded, i_comp_above_upper, i_comp_below_burst;
  logic i_comp_above_burst_hys, i_clamp_above_threshold, heavy, hi;
  logic [7:0] i_limit_set, o_current_limit;
  logic o_gate, o_hv_source_on, o_run_charge, o_limit_capped, o_standby;
  logic o_burst, o_overload_off, o_open_loop_fault, o_feedback_pullup;
  logic o_err_amp_en, o_int_comp_res;
  int failures = 0, tests_run = 0, cyc = 0, n;
  offline_pwm_fault_sequencer #(.VARIANT(2'h2), .SS_CYCLES(SS),
    .RESTART_CYCLES(32'h3e8)) DUT (.i_clk, .i_sys_rst, .i_bulk_above_start,
    .i_vdd_above_on, .i_vdd_above_hv_on, .i_vdd_above_off, .i_pwm_trip,
    .i_ocp_trip, .i_limit_set, .i_feedback_grounded, .i_comp_above_upper,
    .i_comp_below_burst, .i_comp_above_burst_hys, .i_clamp_above_threshold,
    .o_gate, .o_hv_source_on, .o_run_charge, .o_current_limit,
    .o_limit_capped, .o_standby, .o_burst, .o_overload_off,
    .o_open_loop_fault, .o_feedback_pullup, .o_err_amp_en, .o_int_comp_res);
  flyback_stage_model u_stage (.i_clk, .i_gate(o_gate), .i_heavy(heavy),
    .o_pwm_trip(i_pwm_trip), .o_ocp_trip(i_ocp_trip));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Hang guard, well beyond the planned run
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  // Step k cycles, noting any on-time of the switch
  task automatic watch(input int k);
    hi = 1'b0;
    repeat (k)
    begin
      step();
      if (o_gate === 1'b1) hi = 1'b1;
    end
  endtask
  // Next on-time length; each wait is bounded at 4000 cycles
  task automatic on_time();
    // Let a partly seen on-time finish so only whole ones are measured
    n = 0;
    while (o_gate === 1'b1 && n < 4000)
    begin
      step();
      n++;
    end
    n = 0;
    while (o_gate !== 1'b1 && n < 4000)
    begin
      step();
      n++;
    end
    n = 0;
    while (o_gate === 1'b1 && n < 4000)
    begin
      step();
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    repeat (4) step();
    i_bulk_above_start = 1'b1;
    repeat (4) step();
    chk(o_hv_source_on, 8'h01);
    chk(o_gate, 8'h00);
    {i_vdd_above_off, i_vdd_above_hv_on, i_vdd_above_on} = 3'h7;
    repeat (3) step();
    chk(o_hv_source_on, 8'h00);
    chk(o_current_limit < 8'hff, 8'h01);
    on_time();
    chk(n > 0, 8'h01);
  endtask
  task automatic t_pwm();
    repeat (SS) step();
    chk(o_current_limit, 8'hff);
    on_time();
    chk(n >= 40 && n <= 44, 8'h01);
    heavy = 1'b1;
    on_time();
    chk(n >= 20 && n <= 24, 8'h01);
    chk(o_overload_off, 8'h00);
    chk(o_open_loop_fault, 8'h00);
    heavy = 1'b0;
    i_limit_set = 8'h80;
    repeat (4) step();
    chk(o_current_limit <= 8'h80, 8'h01);
    i_limit_set = 8'hff;
    i_comp_above_upper = 1'b1;
    repeat (4) step();
    chk(o_limit_capped, 8'h01);
    i_comp_above_upper = 1'b0;
  endtask
  task automatic t_feedback();
    i_feedback_grounded = 1'b1;
    repeat (4) step();
    chk({o_err_amp_en, o_int_comp_res, o_feedback_pullup}, 8'h03);
    i_feedback_grounded = 1'b0;
    repeat (4) step();
    chk({o_err_amp_en, o_int_comp_res}, 8'h02);
  endtask
  task automatic t_open_loop();
    i_clamp_above_threshold = 1'b1;
    repeat (2000) step();
    chk(o_open_loop_fault, 8'h00);
    heavy = 1'b1;
    n = 0;
    while (o_open_loop_fault !== 1'b1 && n < 4000)
    begin
      step();
      n++;
    end
    chk(o_open_loop_fault, 8'h01);
    {heavy, i_clamp_above_threshold} = 2'h0;
  endtask
  task automatic t_burst();
    i_comp_below_burst = 1'b1;
    repeat (4) step();
    chk({o_burst, o_standby}, 8'h03);
    chk(o_current_limit <= 8'h3d, 8'h01);
    watch(2000);
    chk(hi, 8'h00);
    i_comp_below_burst = 1'b0;
    watch(2000);
    chk(hi, 8'h00);
    i_comp_above_burst_hys = 1'b1;
    on_time();
    chk(n > 0, 8'h01);
    chk(o_standby, 8'h00);
  endtask
  task automatic t_uvlo();
    {i_vdd_above_off, i_vdd_above_hv_on, i_vdd_above_on} = 3'h0;
    repeat (3) step();
    watch(2000);
    chk(hi, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset, then the scenarios in supply order
  initial
  begin
    {i_sys_rst, i_bulk_above_start, i_vdd_above_on, heavy} = 4'h8;
    {i_vdd_above_hv_on, i_vdd_above_off, i_feedback_grounded} = 3'h0;
    {i_comp_above_upper, i_comp_below_burst} = 2'h0;
    {i_comp_above_burst_hys, i_clamp_above_threshold} = 2'h0;
    i_limit_set = 8'hff;
    repeat (12) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    t_startup();
    t_pwm();
    t_feedback();
    t_open_loop();
    t_burst();
    t_uvlo();
    final_report();
  end
endmodule
`default_nettype wire
